// file: verilog/dmaev_pkg.sv
// Package for the DMA channel event control block
`default_nettype none
package dmaev_pkg;

  // Register byte offsets
  localparam logic [3:0] ECON_OFFS     = 4'h0;
  localparam logic [3:0] STATUS_OFFS   = 4'h4;
  localparam logic [3:0] IRQ_STAT_OFFS = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFFS = 4'hC;
  localparam int         ADDR_W        = 4;

  // Event control field positions
  localparam int AIRQ_HI   = 23;
  localparam int AIRQ_LO   = 16;
  localparam int SIRQ_HI   = 15;
  localparam int SIRQ_LO   = 8;
  localparam int FORCE_BIT = 7;
  localparam int ABORT_BIT = 6;
  localparam int PATTERN_ABORT_ENABLE_BIT = 5;
  localparam int START_IRQ_ENABLE_BIT = 4;
  localparam int ABORT_IRQ_ENABLE_BIT = 3;

  // Control register fields at reset
  localparam logic [7:0] SEL_RST = 8'hFF;

  // Status register: bit 0 channel enable, bit 1 abort flag
  localparam int ST_EN_BIT    = 0;
  localparam int ST_ABORT_BIT = 1;

  // Interrupt status bits: start, abort, pattern abort
  localparam int EV_START = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_PAT   = 2;
  localparam int EV_W     = 3;

  // AXI4-Lite response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Event control settings
  typedef struct packed {
    logic [7:0] abort_irq_select;
    logic [7:0] start_irq_select;
    logic       pattern_abort_enable;
    logic       start_irq_enable;
    logic       abort_irq_enable;
  } dmaev_ctrl_s;

  // Strobes toward the channel transfer logic
  typedef struct packed {
    logic start;
    logic abort;
    logic clr_enable;
  } dmaev_cmd_s;

endpackage
`default_nettype wire

// file: verilog/dmaev_irq_match.sv
// Interrupt request number matcher with registered hit outputs
`timescale 1ns/1ns
`default_nettype none

module dmaev_irq_match (
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       irq_valid_i,
  input  wire logic [7:0] irq_num_i,
  input  wire logic [7:0] start_sel_i,
  input  wire logic [7:0] abort_sel_i,
  output logic            start_hit_o,
  output logic            abort_hit_o
);

  typedef struct packed {
    logic start_hit;
    logic abort_hit;
  } dmaev_match_state_s;

  dmaev_match_state_s st_r;
  dmaev_match_state_s st_nxt;

  // Compare the incoming number against both selectors
  always_comb begin
    st_nxt.start_hit = irq_valid_i && (irq_num_i == start_sel_i);
    st_nxt.abort_hit = irq_valid_i && (irq_num_i == abort_sel_i);
  end

  // One cycle pipeline keeps the compare off the control path
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign start_hit_o = st_r.start_hit;
  assign abort_hit_o = st_r.abort_hit;

endmodule

`default_nettype wire

// file: verilog/dmaev_top.sv
// DMA channel event control with AXI4-Lite register access
// Function
// - Bits 23:16 select abort IRQ; match while enabled aborts and sets abort flag.
// - Bits 15:8 select the IRQ number that starts a transfer.
// - Writing one to bit 7 forces a transfer start; reads zero.
// - Writing one to bit 6 aborts the transfer; reads zero.
// - Bit 5 set: pattern match aborts and clears channel enable.
// - Bit 4 set: matching start IRQ starts a cell transfer; else ignored.
// - Bit 3 set: matching abort IRQ aborts transfer; else ignored.
// - Reset: selectors all ones, the five control bits zero.
// - Bits 31:24 and 2:0 read zero and ignore writes.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none

module dmaev_top (
  input  wire logic                     sys_clk_i,
  input  wire logic                     arst_n_i,
  // AXI4-Lite slave
  input  wire logic [dmaev_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [dmaev_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // System interrupt request lines, same clock
  input  wire logic                     irq_valid_i,
  input  wire logic [7:0]               irq_num_i,
  // Channel transfer logic
  input  wire logic                     channel_enable_i,
  input  wire logic                     pattern_match_i,
  input  wire logic                     abort_flag_clr_i,
  output logic                          xfer_start_o,
  output logic                          xfer_abort_o,
  output logic                          channel_enable_clr_o,
  output logic                          channel_abort_flag_o,
  output logic                          irq_o
);
  import dmaev_pkg::*;

  typedef struct packed {
    dmaev_ctrl_s          ctrl;
    dmaev_cmd_s           cmd;
    logic                 abort_flag;
    logic [EV_W-1:0]      ev_stat;
    logic [EV_W-1:0]      ev_mask;
    logic                 irq;
    logic                 aw_got;
    logic [ADDR_W-1:0]    aw_addr;
    logic                 w_got;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic                 awready;
    logic                 wready;
    logic                 arready;
  } dmaev_state_s;

  dmaev_state_s st_r;
  dmaev_state_s st_nxt;
  logic         start_hit;
  logic         abort_hit;

  // Byte-lane merge used by the event control register
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Register image of the event control word
  function automatic logic [31:0] econ_word(input dmaev_ctrl_s c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[AIRQ_HI:AIRQ_LO] = c.abort_irq_select;
    w[SIRQ_HI:SIRQ_LO] = c.start_irq_select;
    w[PATTERN_ABORT_ENABLE_BIT]       = c.pattern_abort_enable;
    w[START_IRQ_ENABLE_BIT]      = c.start_irq_enable;
    w[ABORT_IRQ_ENABLE_BIT]      = c.abort_irq_enable;
    return w;                                            // force and abort read zero
  endfunction

  dmaev_irq_match u_match (
    .sys_clk_i   (sys_clk_i),
    .arst_n_i    (arst_n_i),
    .irq_valid_i (irq_valid_i),
    .irq_num_i   (irq_num_i),
    .start_sel_i (st_r.ctrl.start_irq_select),
    .abort_sel_i (st_r.ctrl.abort_irq_select),
    .start_hit_o (start_hit),
    .abort_hit_o (abort_hit)
  );

  // Next-state logic: bus slave, event control and interrupts
  always_comb begin
    logic        do_wr;
    logic        wr_force;
    logic        wr_abort;
    logic [31:0] wv;
    logic        irq_start;
    logic        irq_abort;
    logic        pat_abort;
    logic        any_abort;
    logic        any_start;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    do_wr     = 1'b0;
    wr_force  = 1'b0;
    wr_abort  = 1'b0;
    wv        = 32'h0000_0000;
    ev_clr    = '0;
    irq_start = 1'b0;
    irq_abort = 1'b0;
    pat_abort = 1'b0;
    any_abort = 1'b0;
    any_start = 1'b0;
    ev_set    = '0;
    st_nxt    = st_r;

    // Accept address and data in either order
    if (s_axi_awvalid && !st_r.aw_got) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_got) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end

    // Commit the write once both halves are held and no response pends
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      do_wr          = 1'b1;
      st_nxt.aw_got  = 1'b0;
      st_nxt.w_got   = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = RESP_OKAY;
      unique case (st_r.aw_addr)
        ECON_OFFS: begin
          wv = merge(econ_word(st_r.ctrl), st_r.w_data, st_r.w_strb);
          st_nxt.ctrl.abort_irq_select     = wv[AIRQ_HI:AIRQ_LO];
          st_nxt.ctrl.start_irq_select     = wv[SIRQ_HI:SIRQ_LO];
          st_nxt.ctrl.pattern_abort_enable = wv[PATTERN_ABORT_ENABLE_BIT];
          st_nxt.ctrl.start_irq_enable     = wv[START_IRQ_ENABLE_BIT];
          st_nxt.ctrl.abort_irq_enable     = wv[ABORT_IRQ_ENABLE_BIT];
          // Set-only strobes only act from a written byte 0
          wr_force = st_r.w_strb[0] && st_r.w_data[FORCE_BIT];
          wr_abort = st_r.w_strb[0] && st_r.w_data[ABORT_BIT];
        end
        STATUS_OFFS: begin
          st_nxt.bresp = RESP_OKAY;
        end
        IRQ_STAT_OFFS: begin
          if (st_r.w_strb[0]) begin
            ev_clr = st_r.w_data[EV_W-1:0];
          end
        end
        IRQ_MASK_OFFS: begin
          if (st_r.w_strb[0]) begin
            st_nxt.ev_mask = st_r.w_data[EV_W-1:0];
          end
        end
        default: begin
          st_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        ECON_OFFS:     st_nxt.rdata = econ_word(st_r.ctrl);
        STATUS_OFFS:   st_nxt.rdata = {30'h0, st_r.abort_flag, channel_enable_i};
        IRQ_STAT_OFFS: st_nxt.rdata = {29'h0, st_r.ev_stat};
        IRQ_MASK_OFFS: st_nxt.rdata = {29'h0, st_r.ev_mask};
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Trigger sources
    irq_start = start_hit && st_r.ctrl.start_irq_enable;
    irq_abort = abort_hit && st_r.ctrl.abort_irq_enable;
    pat_abort = pattern_match_i && st_r.ctrl.pattern_abort_enable;
    any_abort = irq_abort || wr_abort || pat_abort;
    // Abort wins over a start in the same cycle; disabled channel drops starts
    any_start = (irq_start || wr_force) && channel_enable_i && !any_abort;

    st_nxt.cmd.start      = any_start;
    st_nxt.cmd.abort      = any_abort;
    st_nxt.cmd.clr_enable = pat_abort;

    // Abort flag: set by the selected abort IRQ, set wins over clear
    if (irq_abort) begin
      st_nxt.abort_flag = 1'b1;
    end else if (abort_flag_clr_i) begin
      st_nxt.abort_flag = 1'b0;
    end

    // Sticky events, a set beats a write-one clear
    ev_set = '0;
    ev_set[EV_START] = any_start;
    ev_set[EV_ABORT] = any_abort;
    ev_set[EV_PAT]   = pat_abort;
    st_nxt.ev_stat = (st_r.ev_stat & ~ev_clr) | ev_set;
    st_nxt.irq     = |(st_nxt.ev_stat & st_nxt.ev_mask);

    // Ready flags registered so the bus pins come straight from flops
    st_nxt.awready = !st_nxt.aw_got;
    st_nxt.wready  = !st_nxt.w_got;
    st_nxt.arready = !st_nxt.rvalid;
  end

  // State register with reset values
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '0;
      st_r.ctrl.abort_irq_select <= SEL_RST;
      st_r.ctrl.start_irq_select <= SEL_RST;
      st_r.awready               <= 1'b1;
      st_r.wready                <= 1'b1;
      st_r.arready               <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready        = st_r.awready;
  assign s_axi_wready         = st_r.wready;
  assign s_axi_bvalid         = st_r.bvalid;
  assign s_axi_bresp          = st_r.bresp;
  assign s_axi_arready        = st_r.arready;
  assign s_axi_rvalid         = st_r.rvalid;
  assign s_axi_rdata          = st_r.rdata;
  assign s_axi_rresp          = st_r.rresp;
  assign xfer_start_o         = st_r.cmd.start;
  assign xfer_abort_o         = st_r.cmd.abort;
  assign channel_enable_clr_o = st_r.cmd.clr_enable;
  assign channel_abort_flag_o = st_r.abort_flag;
  assign irq_o                = st_r.irq;

  // Selected, enabled abort IRQ aborts two cycles later and sets the flag
  sequence abort_irq_seen_s;
    irq_valid_i && irq_num_i == st_r.ctrl.abort_irq_select && st_r.ctrl.abort_irq_enable;
  endsequence
  abort_irq_hit_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    abort_irq_seen_s ##1 $stable(st_r.ctrl) |=> xfer_abort_o && channel_abort_flag_o)
    else $error("abort irq did not abort");

  start_irq_hit_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    start_hit && st_r.ctrl.start_irq_enable && channel_enable_i && !pattern_match_i && !abort_hit
    && !(st_r.aw_got && st_r.w_got) |=> xfer_start_o)
    else $error("start irq did not start");

  force_read_zero_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    s_axi_rvalid && $past(s_axi_araddr) == ECON_OFFS |-> s_axi_rdata[FORCE_BIT] == 1'b0)
    else $error("force bit read nonzero");

  abort_read_zero_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    s_axi_rvalid && $past(s_axi_araddr) == ECON_OFFS |-> s_axi_rdata[ABORT_BIT] == 1'b0)
    else $error("abort bit read nonzero");

  pattern_abort_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    pattern_match_i |=> channel_enable_clr_o == $past(st_r.ctrl.pattern_abort_enable))
    else $error("pattern abort mismatch");

  start_gate_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !st_r.ctrl.start_irq_enable && !(st_r.aw_got && st_r.w_got) |=> !xfer_start_o)
    else $error("start while start irq disabled");

  abort_gate_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !st_r.ctrl.abort_irq_enable && !st_r.abort_flag && !(st_r.aw_got && st_r.w_got)
    |=> !channel_abort_flag_o)
    else $error("abort flag set while abort irq disabled");

  reset_value_a: assert property (@(posedge sys_clk_i)
    $rose(arst_n_i) |-> st_r.ctrl == {SEL_RST, SEL_RST, 3'b000})
    else $error("control reset value wrong");

  unimpl_zero_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    s_axi_rvalid && $past(s_axi_araddr) == ECON_OFFS |-> s_axi_rdata[31:24] == 8'h00
    && s_axi_rdata[2:0] == 3'h0)
    else $error("unimplemented bits nonzero");

  disabled_no_start_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !channel_enable_i |=> !xfer_start_o)
    else $error("start while channel disabled");

  // A committing event control write with byte 0 enabled
  sequence econ_commit_s;
    st_r.aw_got && st_r.w_got && !st_r.bvalid && st_r.aw_addr == ECON_OFFS && st_r.w_strb[0];
  endsequence
  force_start_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    econ_commit_s ##0 (st_r.w_data[FORCE_BIT] && !st_r.w_data[ABORT_BIT] && channel_enable_i
    && !pattern_match_i && !abort_hit) |=> xfer_start_o)
    else $error("forced start missing");

  abort_strobe_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    econ_commit_s ##0 st_r.w_data[ABORT_BIT] |=> xfer_abort_o && !xfer_start_o)
    else $error("written abort missing");

  // Clear only loses against a simultaneous enabled abort match
  flag_clear_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    abort_flag_clr_i && !(abort_hit && st_r.ctrl.abort_irq_enable) |=> !channel_abort_flag_o)
    else $error("abort flag not cleared");

endmodule

`default_nettype wire

// file: bench/dmaev_far_model.sv
// Far-side model: interrupt request lines and channel transfer logic
`timescale 1ns/1ns
`default_nettype none

module dmaev_far_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic       en_clr_i,
  output logic            irq_valid_o,
  output logic [7:0]      irq_num_o,
  output logic            en_o,
  output logic            pat_o,
  output logic            flag_clr_o
);
  int         n_st  = 0;
  int         n_ab  = 0;
  int         n_cl  = 0;
  int         n_bad = 0;
  // Request flags set by the tasks; only the clocked process drives the lines
  logic       irq_q = 1'b0;
  logic [7:0] num_q = 8'h00;
  logic       pat_q = 1'b0;
  logic       clr_q = 1'b0;
  logic       en_q  = 1'b0;
  logic       en_ld = 1'b0;

  // Tally strobes and drive the lines one edge after each request
  always @(posedge clk_i) begin
    if (start_i === 1'b1) n_st <= n_st + 1;
    if (start_i === 1'b1 && !en_o) n_bad <= n_bad + 1;
    if (abort_i === 1'b1) n_ab <= n_ab + 1;
    if (en_clr_i === 1'b1) n_cl <= n_cl + 1;
    irq_valid_o <= rst_n_i && irq_q;
    irq_num_o   <= irq_q ? num_q : ~num_q; // Idle number inverted so a stale match cannot hide
    pat_o       <= rst_n_i && pat_q;
    flag_clr_o  <= rst_n_i && clr_q;
    // A pattern abort drops the enable as the real channel does
    if (!rst_n_i || en_clr_i === 1'b1) begin
      en_o <= 1'b0;
    end else if (en_ld) begin
      en_o <= en_q;
    end
  end

  // One-cycle request, then a quiet edge before returning
  task automatic irq(input logic [7:0] n);
    @(posedge clk_i);
    irq_q <= 1'b1;
    num_q <= n;
    @(posedge clk_i);
    irq_q <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic pat;
    @(posedge clk_i);
    pat_q <= 1'b1;
    @(posedge clk_i);
    pat_q <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic clr;
    @(posedge clk_i);
    clr_q <= 1'b1;
    @(posedge clk_i);
    clr_q <= 1'b0;
    @(posedge clk_i);
  endtask

  // Channel enable as the transfer logic would set it
  task automatic set_en(input logic v);
    @(posedge clk_i);
    en_q  <= v;
    en_ld <= 1'b1;
    @(posedge clk_i);
    en_ld <= 1'b0;
  endtask
endmodule

`default_nettype wire

// file: bench/dmaev_top_tb_top.sv
// Register-driven testbench for the DMA channel event control block
`timescale 1ns/1ns
`default_nettype none

module dmaev_top_tb_top;
  import dmaev_pkg::*;
  logic              sys_clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              irq_v, en, pm, fclr, xs, xa, ecl, aflag, irq;
  logic [7:0]        irq_n;
  logic              i0;
  int                miscompares = 0;
  int                compares = 0;
  int                e_st = 0;
  int                e_ab = 0;
  int                e_cl = 0;

  dmaev_top u_dut (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_valid_i(irq_v),
    .irq_num_i(irq_n), .channel_enable_i(en), .pattern_match_i(pm), .abort_flag_clr_i(fclr),
    .xfer_start_o(xs), .xfer_abort_o(xa), .channel_enable_clr_o(ecl), .channel_abort_flag_o(aflag),
    .irq_o(irq));

  dmaev_far_model u_far (.clk_i(sys_clk), .rst_n_i(arst_n), .start_i(xs), .abort_i(xa), .en_clr_i(ecl),
    .irq_valid_o(irq_v),
    .irq_num_o(irq_n), .en_o(en), .pat_o(pm), .flag_clr_o(fclr));

  // Clock generator
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    // Idle edge first, so a ready just released is never raised in the same step
    @(posedge sys_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata, ed);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  // Let strobes land, then compare running tallies of the far side
  task automatic ev(input int ds, input int da, input int dc);
    e_st += ds;
    e_ab += da;
    e_cl += dc;
    repeat (6) @(posedge sys_clk);
    chk("starts", u_far.n_st, e_st);
    chk("aborts", u_far.n_ab, e_ab);
    chk("enable clears", u_far.n_cl, e_cl);
    chk("starts while disabled", u_far.n_bad, 0);
  endtask

  function automatic logic [31:0] ec(input logic [7:0] lo);
    return {8'h00, 8'h12, 8'h34, lo};
  endfunction

  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 240 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(ECON_OFFS, 32'h00FFFF00, RESP_OKAY);
    rd(STATUS_OFFS, 32'h0, RESP_OKAY);
    wr(ECON_OFFS, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
    rd(ECON_OFFS, 32'h00FFFF38, RESP_OKAY);
    ev(0, 1, 0);
    $display("test fields done");
    wr(ECON_OFFS, ec(8'h18), 4'hF, RESP_OKAY);
    u_far.set_en(1'b1);
    u_far.irq(8'h34);
    ev(1, 0, 0);
    u_far.irq(8'h35);
    ev(0, 0, 0);
    u_far.irq(8'h12);
    ev(0, 1, 0);
    rd(STATUS_OFFS, 32'h3, RESP_OKAY);
    chk("abort flag pin set", {31'h0, aflag}, 32'h1);
    u_far.clr();
    rd(STATUS_OFFS, 32'h1, RESP_OKAY);
    chk("abort flag pin clear", {31'h0, aflag}, 32'h0);
    wr(ECON_OFFS, ec(8'h08), 4'hF, RESP_OKAY);
    u_far.irq(8'h34);
    ev(0, 0, 0);
    wr(ECON_OFFS, ec(8'h10), 4'hF, RESP_OKAY);
    u_far.irq(8'h12);
    ev(0, 0, 0);
    wr(ECON_OFFS, ec(8'h88), 4'hF, RESP_OKAY);
    ev(1, 0, 0);
    rd(ECON_OFFS, ec(8'h08), RESP_OKAY);
    wr(ECON_OFFS, ec(8'h58), 4'hF, RESP_OKAY);
    ev(0, 1, 0);
    rd(STATUS_OFFS, 32'h1, RESP_OKAY);
    $display("test events done");
    u_far.set_en(1'b0);
    wr(ECON_OFFS, ec(8'h98), 4'hF, RESP_OKAY);
    u_far.irq(8'h34);
    ev(0, 0, 0);
    u_far.set_en(1'b1);
    u_far.pat();
    ev(0, 0, 0);
    wr(ECON_OFFS, ec(8'h38), 4'hF, RESP_OKAY);
    u_far.pat();
    ev(0, 1, 1);
    rd(STATUS_OFFS, 32'h0, RESP_OKAY);
    $display("test gating done");
    // Selector extremes and a single byte lane
    u_far.set_en(1'b1);
    wr(ECON_OFFS, 32'h0000FF18, 4'hF, RESP_OKAY);
    u_far.irq(8'hFF);
    ev(1, 0, 0);
    u_far.irq(8'h00);
    ev(0, 1, 0);
    u_far.clr();
    wr(ECON_OFFS, 32'h00550000, 4'h4, RESP_OKAY);
    rd(ECON_OFFS, 32'h0055FF18, RESP_OKAY);
    $display("test selectors done");
    // Sticky status, mask and the level output
    wr(IRQ_STAT_OFFS, 32'h7, 4'hF, RESP_OKAY);
    wr(IRQ_MASK_OFFS, 32'h0, 4'hF, RESP_OKAY);
    rd(IRQ_STAT_OFFS, 32'h0, RESP_OKAY);
    wr(ECON_OFFS, 32'h0055FF98, 4'hF, RESP_OKAY);
    ev(1, 0, 0);
    rd(IRQ_STAT_OFFS, 32'h1, RESP_OKAY);
    i0 = irq;
    wr(IRQ_MASK_OFFS, 32'h7, 4'hF, RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk("irq while masked", {31'h0, i0}, 32'h0);
    chk("irq when unmasked", {31'h0, irq}, 32'h1);
    wr(IRQ_STAT_OFFS, 32'h1, 4'hF, RESP_OKAY);
    rd(IRQ_STAT_OFFS, 32'h0, RESP_OKAY);
    chk("irq after clear", {31'h0, irq}, 32'h0);
    $display("test interrupts done");
    // Misaligned address is refused and changes nothing
    rd(4'h6, 32'h0, RESP_SLVERR);
    wr(4'h6, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
    rd(ECON_OFFS, 32'h0055FF18, RESP_OKAY);
    $display("test unmapped done");
    stop_test();
  end
endmodule

`default_nettype wire
